/* pgb_port.sv */
/*
  Parallel GPIO bus port: five single pins, a strobed byte bus, alternate pin
  roles, interrupt status and an AXI4-Lite register slave.
  Assumes the board resolves each pin from its output and output enable.
// Functional notes
// - Thirteen pins: five single, eight bus.
// - All pins are inputs after reset.
// - Each single pin has own direction.
// - Bus pins move together as one byte.
// - Low strobe, at least 50ns, pin four/five.
// - Read strobe captures bus byte into latch.
// - Write strobe drives stored byte onto bus.
// - Frame jumper: pin one sampled as frame start.
// - Battery jumper: pin two sampled as low battery.
// - Supply pin high enables, input leaves it external.
// - Alternate roles default only before revision 13.0.
*/
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module pgb_port #(
  parameter int HW_REV_X10 = 130
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic frame_mark_or_gpio_pin_i,
  output logic frame_mark_or_gpio_pin_o,
  output logic frame_mark_or_gpio_pin_oe,
  input wire logic battery_status_or_gpio_pin_i,
  output logic battery_status_or_gpio_pin_o,
  output logic battery_status_or_gpio_pin_oe,
  input wire logic periph_supply_or_gpio_pin_i,
  output logic periph_supply_or_gpio_pin_o,
  output logic periph_supply_or_gpio_pin_oe,
  input wire logic gpio_pin_four_i,
  output logic gpio_pin_four_o,
  output logic gpio_pin_four_oe,
  input wire logic gpio_pin_five_i,
  output logic gpio_pin_five_o,
  output logic gpio_pin_five_oe,
  input wire logic [7:0] parallel_byte_pins_i,
  output logic [7:0] parallel_byte_pins_o,
  output logic parallel_byte_pins_oe,
  input wire logic supply_jumper,
  input wire logic frame_jumper,
  input wire logic battery_jumper,
  output logic irq
);
  // Legacy boards power up with the alternate roles armed.
  localparam logic [2:0] ALT_RST = (HW_REV_X10 < pgb_pkg::ALT_REV_X10) ?
    pgb_pkg::ALT_LEGACY_RST : pgb_pkg::ALT_MODERN_RST;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [7:0] wdata;
    logic wlane;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [7:0] rdata;
    logic [4:0] dir;
    logic [4:0] out;
    logic bus_mode;
    logic [2:0] alt_en;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;
    logic [3:0] int_stat;
    logic [3:0] int_en;
    pgb_pkg::pgb_state_type state;
    logic [2:0] cnt;
    logic frame_d;
    logic batt_d;
    logic [4:0] pin_o;
    logic [4:0] pin_oe;
    logic [7:0] bus_o;
    logic bus_oe;
    logic irq;
  } pgb_q_type;

  localparam pgb_q_type Q_RST = '{
    state: pgb_pkg::PGB_IDLE,
    alt_en: ALT_RST,
    dir: pgb_pkg::DIR_RST,
    out: pgb_pkg::OUT_RST,
    awready: 1'b1,
    wready: 1'b1,
    arready: 1'b1,
    default: '0
  };

  function automatic logic [7:0] word_addr(input logic [7:0] a);
    return {a[7:2], 2'b00};
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    case (word_addr(a))
      pgb_pkg::OFS_DIR, pgb_pkg::OFS_OUT, pgb_pkg::OFS_IN, pgb_pkg::OFS_BUS_CTRL,
      pgb_pkg::OFS_BUS_CMD, pgb_pkg::OFS_WR_BYTE, pgb_pkg::OFS_RD_BYTE,
      pgb_pkg::OFS_JUMPER, pgb_pkg::OFS_INT_STAT, pgb_pkg::OFS_INT_CLR,
      pgb_pkg::OFS_INT_EN: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  pgb_q_type q;
  pgb_q_type next_q;
  logic [15:0] sync_in;
  logic [15:0] sync_s;
  logic [4:0] pin_s;
  logic [7:0] bus_s;
  logic [2:0] jump_s;
  logic [2:0] alt_act;
  logic [3:0] ev;
  logic [3:0] clr;
  logic do_wr;
  logic start_rd;
  logic start_wr;
  logic busy;

  assign sync_in = {battery_jumper, frame_jumper, supply_jumper, parallel_byte_pins_i,
    gpio_pin_five_i, gpio_pin_four_i, periph_supply_or_gpio_pin_i,
    battery_status_or_gpio_pin_i, frame_mark_or_gpio_pin_i};

  pgb_sync #(
    .W(16)
  ) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .async_in(sync_in),
    .sync_out(sync_s)
  );

  assign pin_s = sync_s[4:0];
  assign bus_s = sync_s[12:5];
  assign jump_s = {sync_s[13], sync_s[15], sync_s[14]};

  always_comb begin
    next_q = q;
    busy = q.state != pgb_pkg::PGB_IDLE;
    alt_act = q.alt_en & {jump_s[pgb_pkg::ALT_SUPPLY], jump_s[pgb_pkg::ALT_BATT],
      jump_s[pgb_pkg::ALT_FRAME]};
    ev = 4'h0;
    clr = 4'h0;
    start_rd = 1'b0;
    start_wr = 1'b0;

    if (s_axi_awvalid && q.awready) begin
      next_q.aw_got = 1'b1;
      next_q.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      next_q.w_got = 1'b1;
      next_q.wdata = s_axi_wdata[7:0];
      next_q.wlane = s_axi_wstrb[0];
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end
    do_wr = next_q.aw_got && next_q.w_got && !q.bvalid;
    if (do_wr) begin
      next_q.aw_got = 1'b0;
      next_q.w_got = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = is_mapped(next_q.awaddr) ? pgb_pkg::RESP_OKAY : pgb_pkg::RESP_SLVERR;
      if (next_q.wlane) begin
        case (word_addr(next_q.awaddr))
          pgb_pkg::OFS_DIR: next_q.dir = next_q.wdata[4:0];
          pgb_pkg::OFS_OUT: next_q.out = next_q.wdata[4:0];
          pgb_pkg::OFS_BUS_CTRL: begin
            // Mode changes are dropped while the bus is busy so a strobe is never cut short.
            if (!busy) begin
              next_q.bus_mode = next_q.wdata[pgb_pkg::BUS_MODE_BIT];
              next_q.alt_en = next_q.wdata[pgb_pkg::ALT_LSB +: 3];
            end
          end
          pgb_pkg::OFS_BUS_CMD: begin
            start_rd = next_q.wdata[pgb_pkg::CMD_RD_BIT] && q.bus_mode && !busy;
            start_wr = next_q.wdata[pgb_pkg::CMD_WR_BIT] && q.bus_mode && !busy && !start_rd;
          end
          pgb_pkg::OFS_WR_BYTE: begin
            if (!busy) begin
              next_q.wr_byte = next_q.wdata;
            end
          end
          pgb_pkg::OFS_INT_CLR: clr = next_q.wdata[3:0];
          pgb_pkg::OFS_INT_EN: next_q.int_en = next_q.wdata[3:0];
          default: begin
          end
        endcase
      end
    end
    next_q.awready = !next_q.aw_got && !next_q.bvalid;
    next_q.wready = !next_q.w_got && !next_q.bvalid;

    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
      next_q.arready = 1'b1;
    end
    if (s_axi_arvalid && q.arready) begin
      next_q.arready = 1'b0;
      next_q.rvalid = 1'b1;
      next_q.rresp = is_mapped(s_axi_araddr) ? pgb_pkg::RESP_OKAY : pgb_pkg::RESP_SLVERR;
      case (word_addr(s_axi_araddr))
        pgb_pkg::OFS_DIR: next_q.rdata = {3'h0, q.dir};
        pgb_pkg::OFS_OUT: next_q.rdata = {3'h0, q.out};
        pgb_pkg::OFS_IN: next_q.rdata = {3'h0, pin_s};
        pgb_pkg::OFS_BUS_CTRL: next_q.rdata = {4'h0, q.alt_en, q.bus_mode};
        pgb_pkg::OFS_BUS_CMD: next_q.rdata = {7'h00, busy};
        pgb_pkg::OFS_WR_BYTE: next_q.rdata = q.wr_byte;
        pgb_pkg::OFS_RD_BYTE: next_q.rdata = q.rd_byte;
        pgb_pkg::OFS_JUMPER: next_q.rdata = {2'h0, alt_act, jump_s};
        pgb_pkg::OFS_INT_STAT: next_q.rdata = {4'h0, q.int_stat};
        pgb_pkg::OFS_INT_EN: next_q.rdata = {4'h0, q.int_en};
        default: next_q.rdata = 8'h00;
      endcase
    end

    case (q.state)
      pgb_pkg::PGB_IDLE: begin
        if (start_rd) begin
          next_q.state = pgb_pkg::PGB_RD;
          next_q.cnt = pgb_pkg::STROBE_LOAD;
        end else if (start_wr) begin
          next_q.state = pgb_pkg::PGB_WR;
          next_q.cnt = pgb_pkg::STROBE_LOAD;
        end
      end
      pgb_pkg::PGB_RD: begin
        if (q.cnt == 3'h0) begin
          next_q.rd_byte = bus_s;
          ev[pgb_pkg::EV_RD] = 1'b1;
          next_q.state = pgb_pkg::PGB_IDLE;
        end else begin
          next_q.cnt = q.cnt - 3'h1;
        end
      end
      pgb_pkg::PGB_WR: begin
        if (q.cnt == 3'h0) begin
          next_q.state = pgb_pkg::PGB_HOLD;
        end else begin
          next_q.cnt = q.cnt - 3'h1;
        end
      end
      pgb_pkg::PGB_HOLD: begin
        ev[pgb_pkg::EV_WR] = 1'b1;
        next_q.state = pgb_pkg::PGB_IDLE;
      end
      default: next_q.state = pgb_pkg::PGB_IDLE;
    endcase

    next_q.frame_d = pin_s[0];
    next_q.batt_d = pin_s[1];
    ev[pgb_pkg::EV_FRAME] = alt_act[pgb_pkg::ALT_FRAME] && pin_s[0] && !q.frame_d;
    ev[pgb_pkg::EV_BATT] = alt_act[pgb_pkg::ALT_BATT] && !pin_s[1] && q.batt_d;
    // A new event in the clearing cycle survives the clear.
    next_q.int_stat = (q.int_stat & ~clr) | ev;
    next_q.irq = |(next_q.int_stat & next_q.int_en);

    next_q.pin_oe = next_q.dir;
    next_q.pin_o = next_q.out;
    if (alt_act[pgb_pkg::ALT_FRAME]) begin
      next_q.pin_oe[0] = 1'b0;
    end
    if (alt_act[pgb_pkg::ALT_BATT]) begin
      next_q.pin_oe[1] = 1'b0;
    end
    if (next_q.bus_mode) begin
      next_q.pin_oe[pgb_pkg::PIN_RD_STROBE] = 1'b1;
      next_q.pin_oe[pgb_pkg::PIN_WR_STROBE] = 1'b1;
      next_q.pin_o[pgb_pkg::PIN_RD_STROBE] = next_q.state != pgb_pkg::PGB_RD;
      next_q.pin_o[pgb_pkg::PIN_WR_STROBE] = next_q.state != pgb_pkg::PGB_WR;
    end
    next_q.bus_o = next_q.wr_byte;
    next_q.bus_oe = next_q.state == pgb_pkg::PGB_WR || next_q.state == pgb_pkg::PGB_HOLD;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q <= Q_RST;
    end else begin
      q <= next_q;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = {24'h000000, q.rdata};
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign frame_mark_or_gpio_pin_o = q.pin_o[0];
  assign frame_mark_or_gpio_pin_oe = q.pin_oe[0];
  assign battery_status_or_gpio_pin_o = q.pin_o[1];
  assign battery_status_or_gpio_pin_oe = q.pin_oe[1];
  assign periph_supply_or_gpio_pin_o = q.pin_o[2];
  assign periph_supply_or_gpio_pin_oe = q.pin_oe[2];
  assign gpio_pin_four_o = q.pin_o[3];
  assign gpio_pin_four_oe = q.pin_oe[3];
  assign gpio_pin_five_o = q.pin_o[4];
  assign gpio_pin_five_oe = q.pin_oe[4];
  assign parallel_byte_pins_o = q.bus_o;
  assign parallel_byte_pins_oe = q.bus_oe;
  assign irq = q.irq;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  AST_RESET_INPUTS: assert property ($rose(rstn) |-> q.pin_oe == 5'h00 && !q.bus_oe)
    else $error("pins not inputs after reset");
  AST_ALT_DEFAULT: assert property ($rose(rstn) |-> q.alt_en == ALT_RST)
    else $error("alternate role default wrong for revision");
  AST_RD_WIDTH: assert property ($fell(q.pin_o[3]) && q.pin_oe[3] && q.bus_mode |->
    (!q.pin_o[3]) [*5] ##1 q.pin_o[3])
    else $error("read strobe width wrong");
  AST_WR_WIDTH: assert property ($fell(q.pin_o[4]) && q.pin_oe[4] && q.bus_mode |->
    (!q.pin_o[4] && q.bus_oe) [*5] ##1 (q.pin_o[4] && q.bus_oe) ##1 !q.bus_oe)
    else $error("write strobe width or hold wrong");
  AST_RD_CAPTURE: assert property ($rose(q.pin_o[3]) && q.bus_mode && $past(q.bus_mode) |->
    q.rd_byte == $past(bus_s) && q.int_stat[pgb_pkg::EV_RD])
    else $error("read byte not captured at strobe end");
  AST_WR_DATA: assert property (q.bus_oe |-> q.bus_o == q.wr_byte && $stable(q.bus_o)
    or $rose(q.bus_oe))
    else $error("bus byte changed while driven");
  AST_BUS_OE: assert property (q.bus_oe |-> q.bus_mode && (q.state == pgb_pkg::PGB_WR ||
    q.state == pgb_pkg::PGB_HOLD))
    else $error("bus driven outside write transfer");
  AST_FRAME_IN: assert property (q.alt_en[0] && jump_s[pgb_pkg::ALT_FRAME] && $stable(q.alt_en)
    |=> !q.pin_oe[0])
    else $error("frame pin driven in alternate role");
  AST_BATT_IN: assert property (q.alt_en[1] && jump_s[pgb_pkg::ALT_BATT] && $stable(q.alt_en)
    |=> !q.pin_oe[1])
    else $error("battery pin driven in alternate role");
  AST_DIR: assert property (!q.bus_mode |->
    q.pin_oe[4:2] == q.dir[4:2])
    else $error("pin direction does not follow setting");
  AST_SUPPLY: assert property (q.dir[2] |->
    q.pin_oe[2] && q.pin_o[2] == q.out[2])
    else $error("supply pin level does not follow output");
  AST_IRQ: assert property (q.irq == (|(q.int_stat & q.int_en)))
    else $error("interrupt output inconsistent with status");
endmodule
`default_nettype wire

/* pgb_pkg.sv */
/*
  Shared constants and types of the parallel GPIO bus port: register offsets,
  field positions, reset values, strobe timing and the transfer states.
  Assumes a 100 MHz register clock and 32-bit AXI4-Lite register access.
*/
`default_nettype none
package pgb_pkg;
  localparam logic [7:0] OFS_DIR = 8'h00;
  localparam logic [7:0] OFS_OUT = 8'h04;
  localparam logic [7:0] OFS_IN = 8'h08;
  localparam logic [7:0] OFS_BUS_CTRL = 8'h0c;
  localparam logic [7:0] OFS_BUS_CMD = 8'h10;
  localparam logic [7:0] OFS_WR_BYTE = 8'h14;
  localparam logic [7:0] OFS_RD_BYTE = 8'h18;
  localparam logic [7:0] OFS_JUMPER = 8'h1c;
  localparam logic [7:0] OFS_INT_STAT = 8'h20;
  localparam logic [7:0] OFS_INT_CLR = 8'h24;
  localparam logic [7:0] OFS_INT_EN = 8'h28;

  localparam int BUS_MODE_BIT = 0;
  localparam int ALT_LSB = 1;
  localparam int CMD_RD_BIT = 0;
  localparam int CMD_WR_BIT = 1;

  localparam int ALT_FRAME = 0;
  localparam int ALT_BATT = 1;
  localparam int ALT_SUPPLY = 2;

  localparam int EV_RD = 0;
  localparam int EV_WR = 1;
  localparam int EV_FRAME = 2;
  localparam int EV_BATT = 3;

  localparam int PIN_RD_STROBE = 3;
  localparam int PIN_WR_STROBE = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [4:0] DIR_RST = 5'h00;
  localparam logic [4:0] OUT_RST = 5'h00;
  localparam logic [2:0] ALT_LEGACY_RST = 3'h7;
  localparam logic [2:0] ALT_MODERN_RST = 3'h0;
  localparam int ALT_REV_X10 = 130;

  localparam int CLK_NS = 10;
  localparam int STROBE_NS = 50;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] STROBE_LOAD = 3'(STROBE_CYC - 1);

  typedef enum logic [3:0] {
    PGB_IDLE = 4'h1,
    PGB_RD = 4'h2,
    PGB_WR = 4'h4,
    PGB_HOLD = 4'h8
  } pgb_state_type;
endpackage
`default_nettype wire

/* pgb_sync.sv */
/*
  Three-stage input synchroniser with agreement filter.
  Assumes asynchronous inputs; a bit changes once stages two and three agree.
*/
`timescale 1ns/1ns
`default_nettype none
module pgb_sync #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } pgb_sync_q_type;

  pgb_sync_q_type q;
  pgb_sync_q_type next_q;

  always_comb begin
    next_q = q;
    next_q.s1 = async_in;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    next_q.stable = (q.s2 & ~(q.s2 ^ q.s3)) | (q.stable & (q.s2 ^ q.s3));
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign sync_out = q.stable;
endmodule
`default_nettype wire

/* pgb_ext.sv */
/*
  Model of the outside circuits wired to the port's pins.
  Assumes the bench sets the levels that those circuits put on released pins.
*/
`timescale 1ns/1ns
`default_nettype none
module pgb_ext (
  input wire logic [4:0] pin_o,
  input wire logic [4:0] pin_oe,
  input wire logic [4:0] ext_pin,
  input wire logic [7:0] bus_o,
  input wire logic bus_oe,
  input wire logic [7:0] ext_bus,
  output logic [4:0] pin_i,
  output logic [7:0] bus_i,
  output logic [7:0] wr_seen,
  output logic [31:0] low_ns,
  output logic rd_drive
);
  time t_fall = 0;
  // An outside circuit sets a pin only while the port leaves it as an input.
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_pin);
  // The peer lets go of the byte lines while the port drives them, so no contention.
  assign bus_i = bus_oe ? bus_o : ext_bus;
  initial begin
    wr_seen = 8'h00;
    low_ns = 32'h0;
    rd_drive = 1'b0;
  end
  always @(negedge pin_i[3] or negedge pin_i[4]) begin
    t_fall = $time;
  end
  // Width is taken on the resolved line, as the peer sees it.
  always @(posedge pin_i[3] or posedge pin_i[4]) begin
    low_ns = 32'($time - t_fall);
  end
  always @(posedge pin_i[4]) begin
    wr_seen = bus_i;
  end
  always @(pin_i[3] or bus_oe) begin
    if (!pin_i[3] && bus_oe) begin
      rd_drive = 1'b1;
    end
  end
endmodule
`default_nettype wire

/* testbench.sv */
/*
  Self-checking bench of the parallel GPIO bus port over AXI4-Lite.
  Assumes the pin model resolves every pin from both parties' drivers.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic ref_clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr, ext_bus;
  logic [31:0] wdata, seed, v, r;
  logic [4:0] ext_pin;
  logic [2:0] jmp;
  logic [34:0] er;
  logic [34:0] exp_r[$];
  logic [1:0] exp_b[$];
  int err_count, comparisons, cycles;
  wire logic awready, wready, bvalid, arready, rvalid, irq, bus_oe, rd_drive;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata, low_ns;
  wire logic [4:0] pin_o, pin_oe, pin_i;
  wire logic [7:0] bus_o, bus_i, wr_seen;

  pgb_port i_pgb_port (.ref_clk(ref_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .frame_mark_or_gpio_pin_i(pin_i[0]), .frame_mark_or_gpio_pin_o(pin_o[0]),
    .frame_mark_or_gpio_pin_oe(pin_oe[0]), .battery_status_or_gpio_pin_i(pin_i[1]),
    .battery_status_or_gpio_pin_o(pin_o[1]), .battery_status_or_gpio_pin_oe(pin_oe[1]),
    .periph_supply_or_gpio_pin_i(pin_i[2]), .periph_supply_or_gpio_pin_o(pin_o[2]),
    .periph_supply_or_gpio_pin_oe(pin_oe[2]), .gpio_pin_four_i(pin_i[3]),
    .gpio_pin_four_o(pin_o[3]), .gpio_pin_four_oe(pin_oe[3]), .gpio_pin_five_i(pin_i[4]),
    .gpio_pin_five_o(pin_o[4]), .gpio_pin_five_oe(pin_oe[4]), .parallel_byte_pins_i(bus_i),
    .parallel_byte_pins_o(bus_o), .parallel_byte_pins_oe(bus_oe), .supply_jumper(jmp[2]),
    .frame_jumper(jmp[0]), .battery_jumper(jmp[1]), .irq(irq));

  pgb_ext i_pgb_ext (.pin_o(pin_o), .pin_oe(pin_oe), .ext_pin(ext_pin), .bus_o(bus_o),
    .bus_oe(bus_oe), .ext_bus(ext_bus), .pin_i(pin_i), .bus_i(bus_i), .wr_seen(wr_seen),
    .low_ns(low_ns), .rd_drive(rd_drive));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic wrap_up;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [35:0] s, input logic [35:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  // Each channel is released only at the edge that takes it.
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ha, hw, hb;
    exp_b.push_back(e);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge ref_clk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid && bready;
      @(posedge ref_clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end while (!hb);
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, input logic c, input logic [33:0] e);
    logic ha, hr;
    exp_r.push_back({c, e});
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge ref_clk);
      ha = arvalid && arready;
      hr = rvalid && rready;
      v = rdata;
      @(posedge ref_clk);
      if (ha) arvalid <= 1'b0;
    end while (!hr);
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axw(a, d, pgb_pkg::RESP_OKAY);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    axr(a, 1'b1, {pgb_pkg::RESP_OKAY, e});
  endtask

  // Polling reads are not compared; only the busy flag steers the wait.
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      axr(pgb_pkg::OFS_BUS_CMD, 1'b0, 34'h0);
      n++;
    end while (v[0] !== 1'b0 && n < 40);
    check(36'(v[0]), 36'h0);
  endtask

  always @(posedge ref_clk) begin
    if (rstn && rvalid && rready && exp_r.size() > 0) begin
      er = exp_r.pop_front();
      if (er[34]) check({2'h0, rresp, rdata}, {2'h0, er[33:0]});
    end
    if (rstn && bvalid && bready && exp_b.size() > 0) begin
      check(36'(bresp), 36'(exp_b.pop_front()));
    end
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, ext_bus, wdata} = 56'h0;
    ext_pin = 5'h00;
    jmp = 3'h0;
    seed = 32'h000044c7;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    tick(0);
    check(36'({pin_oe, bus_oe}), 36'h0);
    rd(pgb_pkg::OFS_DIR, 32'h0);
    rd(pgb_pkg::OFS_BUS_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      wr(pgb_pkg::OFS_DIR, {27'h0, r[4:0]});
      wr(pgb_pkg::OFS_OUT, {27'h0, r[9:5]});
      ext_pin <= r[14:10];
      tick(8);
      check(36'(pin_oe), 36'(r[4:0]));
      check(36'(pin_o), 36'(r[9:5]));
      rd(pgb_pkg::OFS_IN, {27'h0, (r[4:0] & r[9:5]) | (~r[4:0] & r[14:10])});
    end
    r = rnd();
    ext_bus <= r[7:0];
    wr(pgb_pkg::OFS_BUS_CTRL, 32'h1);
    wr(pgb_pkg::OFS_BUS_CMD, 32'h1);
    wait_idle();
    rd(pgb_pkg::OFS_RD_BYTE, {24'h0, r[7:0]});
    check(36'(low_ns >= 50), 36'h1);
    check(36'(rd_drive), 36'h0);
    wr(pgb_pkg::OFS_WR_BYTE, {24'h0, r[15:8]});
    wr(pgb_pkg::OFS_BUS_CMD, 32'h2);
    wait_idle();
    tick(2);
    check(36'(wr_seen), 36'(r[15:8]));
    check(36'(low_ns >= 50), 36'h1);
    check(36'(bus_oe), 36'h0);
    rd(pgb_pkg::OFS_INT_STAT, 32'h3);
    wr(pgb_pkg::OFS_INT_EN, 32'h1);
    tick(2);
    check(36'(irq), 36'h1);
    wr(pgb_pkg::OFS_INT_EN, 32'h0);
    tick(2);
    check(36'(irq), 36'h0);
    wr(pgb_pkg::OFS_INT_CLR, 32'h3);
    rd(pgb_pkg::OFS_INT_STAT, 32'h0);
    jmp <= 3'h7;
    ext_pin <= 5'h02;
    wr(pgb_pkg::OFS_BUS_CTRL, 32'h7);
    wr(pgb_pkg::OFS_DIR, 32'h1f);
    tick(8);
    check(36'(pin_oe), 36'h1c);
    rd(pgb_pkg::OFS_JUMPER, 32'h1f);
    @(posedge ref_clk);
    ext_pin <= 5'h01;
    tick(8);
    rd(pgb_pkg::OFS_INT_STAT, 32'hc);
    wr(pgb_pkg::OFS_INT_EN, 32'hc);
    tick(2);
    check(36'(irq), 36'h1);
    axw(8'h30, 32'h0, pgb_pkg::RESP_SLVERR);
    axr(8'h30, 1'b1, {pgb_pkg::RESP_SLVERR, 32'h0});
    wr(pgb_pkg::OFS_IN, 32'h1f);
    tick(2);
    wrap_up();
  end
endmodule
`default_nettype wire
